// *** design/pss_cfg_mem.sv ***
// sequence configuration memory: step table of rail index and delay
// written by the loader, read with a registered output
`timescale 1ns/1ps
module pss_cfg_mem
	import pss_pkg::*;
(
	// clock
	input wire logic clk,
	// write port
	input wire logic wr_en,
	input wire logic [CFG_AW-1:0] wr_addr,
	input wire logic [DLY_W+3:0] wr_data,
	// read port
	input wire logic [CFG_AW-1:0] rd_addr,
	output logic [DLY_W+3:0] rd_data
);
	logic [DLY_W+3:0] mem [NUM_STEPS];

	// plain synchronous ram, no reset on contents
	always_ff @(posedge clk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule

// *** design/pss_pkg.sv ***
// package for the power state sequencer: states, rail groups, timing counts
// assumes a 250 MHz device clock
package pss_pkg;
	localparam int CLK_MHZ = 250;
	localparam int NUM_RAILS = 16;
	localparam int NUM_STEPS = 16;
	localparam int CFG_AW = 4;
	localparam int DLY_W = 12;
	localparam int TASK_W = 4;
	// rail bit position and rail group masks inside the rail vector
	localparam int RAIL_VTT = 0;
	localparam logic [NUM_RAILS-1:0] SLEEP_OFF_MASK = 16'h00f1;
	localparam logic [NUM_RAILS-1:0] SUSPEND_KEEP_MASK = 16'h0f00;
	localparam logic [NUM_RAILS-1:0] HIBERNATE_KEEP_MASK = 16'h0300;
	localparam logic [NUM_RAILS-1:0] RAIL_ALL = 16'hffff;
	// exit limits, in us and in cycles
	localparam int SLEEP_EXIT_US = 200;
	localparam int SUSPEND_EXIT_US = 2000;
	localparam int SLEEP_EXIT_CYC = SLEEP_EXIT_US * CLK_MHZ;
	localparam int SUSPEND_EXIT_CYC = SUSPEND_EXIT_US * CLK_MHZ;
	// modem task delay between steps, in cycles
	localparam logic [DLY_W-1:0] MODEM_DLY_DEF = 12'h0ff;
	// warm reset pulse to the serial interfaces
	localparam logic [DLY_W-1:0] WARM_PULSE = 12'h010;
	// transition codes, ten kinds
	localparam logic [TASK_W-1:0] TR_COLD_BOOT = 4'h0;
	localparam logic [TASK_W-1:0] TR_WARM = 4'h1;
	localparam logic [TASK_W-1:0] TR_SLEEP_IN = 4'h2;
	localparam logic [TASK_W-1:0] TR_SLEEP_OUT = 4'h3;
	localparam logic [TASK_W-1:0] TR_SUSP_IN = 4'h4;
	localparam logic [TASK_W-1:0] TR_SUSP_OUT = 4'h5;
	localparam logic [TASK_W-1:0] TR_HIB_IN = 4'h6;
	localparam logic [TASK_W-1:0] TR_HIB_OUT = 4'h7;
	localparam logic [TASK_W-1:0] TR_COLD_OFF = 4'h8;
	localparam logic [TASK_W-1:0] TR_MODEM = 4'h9;
	localparam logic [TASK_W-1:0] TR_NONE = 4'hf;
	typedef enum logic [3:0] {
		ST_LOAD, ST_DOWN, ST_UP_STEP, ST_UP_WAIT, ST_PWRGOOD, ST_ACTIVE,
		ST_WARM, ST_SLEEP, ST_SUSPEND, ST_HIBERNATE, ST_OFF_STEP,
		ST_OFF_WAIT, ST_NOSUPPLY
	} pss_state_e;
	typedef enum logic [2:0] {
		MD_IDLE, MD_WARN, MD_OFF, MD_ON, MD_DONE
	} pss_modem_e;
endpackage

// *** design/pss_top.sv ***
// power state sequencer: boot load, rail sequencing and sleep transitions
// assumes host sleep pins are asynchronous, config source on same clock
`timescale 1ns/1ps
module pss_top
	import pss_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// configuration load stream
	input wire logic cfg_valid,
	input wire logic [CFG_AW-1:0] cfg_addr,
	input wire logic [DLY_W+3:0] cfg_data,
	input wire logic cfg_done,
	// host sleep pins and events
	input wire logic shallow_sleep_req_n,
	input wire logic suspend_req_n,
	input wire logic hibernate_req_n,
	input wire logic warm_reset_req,
	input wire logic cold_off_req,
	input wire logic wakeup,
	input wire logic supply_low,
	input wire logic step_hold,
	// modem control register bits
	input wire logic modem_reset_seq_bit,
	input wire logic modem_off_bit,
	input wire logic [DLY_W-1:0] modem_delay,
	// outputs to host and rails
	output logic core_power_good,
	output logic platform_reset_n,
	output logic [NUM_RAILS-1:0] rail_en,
	output logic [NUM_RAILS-1:0] rail_save,
	output logic [NUM_RAILS-1:0] clk_req,
	output logic serial_if_reset,
	output logic core_boot_voltage_load,
	output logic shutdown_warning_n,
	output logic modem_off_n,
	output logic under_voltage_flag,
	output logic [TASK_W-1:0] transition
);
	localparam int SLEEP_EXIT_W = $clog2(SLEEP_EXIT_CYC + 1);

	logic rst_s1, rst_s2;
	logic [2:0] pin_s1, pin_s2;
	logic [1:0] ev_s1, ev_s2;
	pss_state_e state, next_state;
	pss_modem_e mstate;
	logic [CFG_AW-1:0] step;
	logic [CFG_AW-1:0] next_step;
	logic [DLY_W-1:0] timer;
	logic [DLY_W+3:0] step_word;
	logic [DLY_W-1:0] mtimer;
	logic mseq_d;
	logic [SLEEP_EXIT_W-1:0] exit_cnt;

	// reset release through two flops
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end

	// pin synchronisers
	always_ff @(posedge clk or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			pin_s1 <= 3'h7;
			pin_s2 <= 3'h7;
			ev_s1 <= 2'h0;
			ev_s2 <= 2'h0;
		end
		else
		begin
			pin_s1 <= {hibernate_req_n, suspend_req_n, shallow_sleep_req_n};
			pin_s2 <= pin_s1;
			ev_s1 <= {wakeup, supply_low};
			ev_s2 <= ev_s1;
		end
	end

	wire sleep_n = pin_s2[0];
	wire susp_n = pin_s2[1];
	wire hib_n = pin_s2[2];
	wire wake_s = ev_s2[1];
	wire uv_s = ev_s2[0];

	// step table read, rail index in top bits, delay below
	pss_cfg_mem u_mem (
		.clk(clk),
		.wr_en(cfg_valid && state == ST_LOAD),
		.wr_addr(cfg_addr),
		.wr_data(cfg_data),
		.rd_addr(next_step),
		.rd_data(step_word)
	);

	wire [3:0] step_rail = step_word[DLY_W+3:DLY_W];
	wire [DLY_W-1:0] step_dly = step_word[DLY_W-1:0];
	wire last_step = (step == CFG_AW'(NUM_STEPS - 1));
	wire timer_done = (timer == '0);
	wire warm_ok = warm_reset_req && state == ST_ACTIVE;
	wire powering_down = (state == ST_OFF_STEP) || (state == ST_OFF_WAIT);

	// next state, one transition at a time
	always_comb
	begin
		next_state = state;
		case (state)
			ST_LOAD:
				if (cfg_done)
					next_state = ST_DOWN;
			ST_DOWN:
				if (wake_s && !uv_s)
					next_state = ST_UP_STEP;
			ST_UP_STEP:
				if (!step_hold)
					next_state = ST_UP_WAIT;
			ST_UP_WAIT:
				if (timer_done)
					next_state = last_step ? ST_PWRGOOD : ST_UP_STEP;
			ST_PWRGOOD:
				next_state = ST_ACTIVE;
			ST_ACTIVE:
				if (uv_s || cold_off_req)
					next_state = ST_OFF_STEP;
				else if (warm_ok)
					next_state = ST_WARM;
				else if (!hib_n)
					next_state = ST_HIBERNATE;
				else if (!susp_n)
					next_state = ST_SUSPEND;
				else if (!sleep_n)
					next_state = ST_SLEEP;
			ST_WARM:
				if (timer_done)
					next_state = ST_ACTIVE;
			ST_SLEEP:
				if (uv_s)
					next_state = ST_OFF_STEP;
				else if (sleep_n)
					next_state = ST_ACTIVE;
			ST_SUSPEND:
				if (uv_s)
					next_state = ST_OFF_STEP;
				else if (susp_n)
					next_state = ST_ACTIVE;
			ST_HIBERNATE:
				if (uv_s)
					next_state = ST_OFF_STEP;
				else if (hib_n)
					next_state = ST_ACTIVE;
			ST_OFF_STEP:
				next_state = ST_OFF_WAIT;
			ST_OFF_WAIT:
				if (timer_done)
					next_state = (step == '0) ?
						(uv_s ? ST_NOSUPPLY : ST_DOWN) : ST_OFF_STEP;
			ST_NOSUPPLY:
				if (!uv_s)
					next_state = ST_DOWN;
			default:
				next_state = ST_LOAD;
		endcase
	end

	// next step pointer; the table is addressed with it so that the
	// registered read word belongs to the step once it is taken
	always_comb
	begin
		next_step = step;
		if (state == ST_DOWN)
			next_step = '0;
		else if (state == ST_UP_WAIT && timer_done && !last_step)
			next_step = step + 1'b1;
		else if (next_state == ST_OFF_STEP && state != ST_OFF_WAIT)
			next_step = CFG_AW'(NUM_STEPS - 1);
		else if (state == ST_OFF_WAIT && timer_done && step != '0)
			next_step = step - 1'b1;
	end

	// state, step pointer and delay timer
	always_ff @(posedge clk or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			state <= ST_LOAD;
			step <= '0;
			timer <= '0;
		end
		else
		begin
			state <= next_state;
			step <= next_step;
			if (next_state == ST_WARM && state == ST_ACTIVE)
				timer <= WARM_PULSE;
			else if (state == ST_UP_STEP || state == ST_OFF_STEP)
				timer <= step_dly;
			else if (!timer_done)
				timer <= timer - 1'b1;
		end
	end

	// rail enables, power-save and clock requests
	always_ff @(posedge clk or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			rail_en <= '0;
			rail_save <= '0;
			clk_req <= '0;
		end
		else
		begin
			if (state == ST_UP_STEP && !step_hold)
				rail_en[step_rail] <= 1'b1;
			else if (state == ST_OFF_STEP)
				rail_en[step_rail] <= 1'b0;
			else if (state == ST_ACTIVE && next_state == ST_SLEEP)
			begin
				rail_en <= rail_en & ~SLEEP_OFF_MASK;
				rail_save <= rail_en & ~SLEEP_OFF_MASK;
			end
			else if (state == ST_ACTIVE && next_state == ST_SUSPEND)
			begin
				rail_en <= rail_en & SUSPEND_KEEP_MASK;
				rail_save <= rail_en & SUSPEND_KEEP_MASK;
			end
			else if (state == ST_ACTIVE && next_state == ST_HIBERNATE)
			begin
				rail_en <= rail_en & HIBERNATE_KEEP_MASK;
				rail_save <= rail_en & HIBERNATE_KEEP_MASK;
			end
			else if (next_state == ST_ACTIVE && (state == ST_SLEEP ||
				state == ST_SUSPEND || state == ST_HIBERNATE))
			begin
				rail_en <= RAIL_ALL;
				rail_save <= '0;
			end
			if (state == ST_DOWN || state == ST_NOSUPPLY)
				rail_save <= '0;
			clk_req <= rail_en & ~rail_save;
		end
	end

	// power good, platform reset and warm reset effects
	always_ff @(posedge clk or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			core_power_good <= 1'b0;
			platform_reset_n <= 1'b0;
			serial_if_reset <= 1'b0;
			core_boot_voltage_load <= 1'b0;
		end
		else
		begin
			core_power_good <= (state == ST_PWRGOOD) ||
				(core_power_good && !powering_down &&
				state != ST_DOWN);
			platform_reset_n <= (state == ST_ACTIVE && next_state != ST_WARM)
				|| state == ST_SLEEP || state == ST_SUSPEND ||
				state == ST_HIBERNATE;
			serial_if_reset <= (next_state == ST_WARM);
			core_boot_voltage_load <= (state == ST_ACTIVE &&
				next_state == ST_WARM);
		end
	end

	// under-voltage flag and transition code
	always_ff @(posedge clk or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			under_voltage_flag <= 1'b0;
			transition <= TR_NONE;
		end
		else
		begin
			if (uv_s)
				under_voltage_flag <= 1'b1;
			else if (state == ST_DOWN)
				under_voltage_flag <= 1'b0;
			if (mstate == MD_WARN)
				transition <= TR_MODEM;
			else if (state != next_state)
				case (next_state)
					ST_UP_STEP: transition <= (state == ST_DOWN) ?
						TR_COLD_BOOT : transition;
					ST_WARM: transition <= TR_WARM;
					ST_SLEEP: transition <= TR_SLEEP_IN;
					ST_SUSPEND: transition <= TR_SUSP_IN;
					ST_HIBERNATE: transition <= TR_HIB_IN;
					ST_OFF_STEP: transition <= (state == ST_OFF_WAIT) ?
						transition : TR_COLD_OFF;
					ST_ACTIVE:
						case (state)
							ST_SLEEP: transition <= TR_SLEEP_OUT;
							ST_SUSPEND: transition <= TR_SUSP_OUT;
							ST_HIBERNATE: transition <= TR_HIB_OUT;
							default: transition <= transition;
						endcase
					default: transition <= transition;
				endcase
		end
	end

	// modem reset task on rising edge of the sequence bit
	wire mseq_start = modem_reset_seq_bit && !mseq_d && mstate == MD_IDLE;
	wire mtimer_done = (mtimer == '0);
	always_ff @(posedge clk or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			mstate <= MD_IDLE;
			mtimer <= '0;
			mseq_d <= 1'b0;
		end
		else
		begin
			mseq_d <= modem_reset_seq_bit;
			if (!mtimer_done)
				mtimer <= mtimer - 1'b1;
			case (mstate)
				MD_IDLE:
					if (mseq_start)
					begin
						mstate <= MD_WARN;
						mtimer <= modem_delay;
					end
				MD_WARN:
					if (mtimer_done)
					begin
						mstate <= MD_OFF;
						mtimer <= modem_delay;
					end
				MD_OFF:
					if (mtimer_done)
					begin
						mstate <= MD_ON;
						mtimer <= modem_delay;
					end
				MD_ON:
					if (mtimer_done)
						mstate <= MD_DONE;
				MD_DONE:
					mstate <= MD_IDLE;
				default:
					mstate <= MD_IDLE;
			endcase
		end
	end

	// warning and modem off pins
	always_ff @(posedge clk or negedge rst_s2)
	begin
		if (!rst_s2)
		begin
			shutdown_warning_n <= 1'b1;
			modem_off_n <= 1'b1;
		end
		else
		begin
			shutdown_warning_n <= !(powering_down ||
				mstate == MD_WARN || mstate == MD_OFF);
			modem_off_n <= !(modem_off_bit || mstate == MD_OFF);
		end
	end

	// cycles spent leaving shallow sleep, saturating; watched below
	always_ff @(posedge clk or negedge rst_s2)
	begin
		if (!rst_s2)
			exit_cnt <= '0;
		else if (state != ST_SLEEP || !sleep_n)
			exit_cnt <= '0;
		else if (exit_cnt != '1)
			exit_cnt <= exit_cnt + 1'b1;
	end

	a_pgood_order: assert property (@(posedge clk) disable iff (!rst_s2)
		$rose(platform_reset_n)
		|-> core_power_good && $past(core_power_good))
		else $error("platform reset released before power good");
	a_warm_only_act: assert property (@(posedge clk) disable iff (!rst_s2)
		state == ST_WARM && $past(state) != ST_WARM
		|-> $past(state) == ST_ACTIVE)
		else $error("warm reset entered outside active");
	a_warm_rails: assert property (@(posedge clk) disable iff (!rst_s2)
		state == ST_WARM |-> $stable(rail_en) && !platform_reset_n)
		else $error("rails changed during warm reset");
	a_warm_serial: assert property (@(posedge clk) disable iff (!rst_s2)
		$rose(serial_if_reset) |-> core_boot_voltage_load
		##1 !core_boot_voltage_load)
		else $error("serial reset stuck with boot voltage load");
	a_sleep_core: assert property (@(posedge clk) disable iff (!rst_s2)
		state == ST_ACTIVE ##1 state == ST_SLEEP
		|-> (rail_en & SLEEP_OFF_MASK) == '0)
		else $error("sleep rails still on in shallow sleep");
	a_sleep_exit: assert property (@(posedge clk) disable iff (!rst_s2)
		state == ST_SLEEP && sleep_n && !uv_s
		|-> ##[1:3] rail_en == RAIL_ALL)
		else $error("shallow sleep exit too slow");
	a_sleep_exit_time: assert property (@(posedge clk) disable iff (!rst_s2)
		exit_cnt < SLEEP_EXIT_W'(SLEEP_EXIT_CYC))
		else $error("shallow sleep exit over its time limit");
	a_susp_exit: assert property (@(posedge clk) disable iff (!rst_s2)
		state == ST_SUSPEND && susp_n && !uv_s
		|-> ##1 state == ST_ACTIVE && rail_save == '0)
		else $error("suspend exit left power save");
	a_down_warn: assert property (@(posedge clk) disable iff (!rst_s2)
		state == ST_OFF_WAIT |-> ##1 !shutdown_warning_n)
		else $error("warning not low during power down");
	a_modem_off: assert property (@(posedge clk) disable iff (!rst_s2)
		modem_off_bit |-> ##1 !modem_off_n)
		else $error("modem off pin not following bit");
	a_uv_flag: assert property (@(posedge clk) disable iff (!rst_s2)
		uv_s |-> ##1 under_voltage_flag)
		else $error("under-voltage flag not raised");
	c_cold_boot: cover property (@(posedge clk) disable iff (!rst_s2)
		state == ST_PWRGOOD ##1 state == ST_ACTIVE);
	c_sleep_round: cover property (@(posedge clk) disable iff (!rst_s2)
		state == ST_SLEEP ##1 state == ST_ACTIVE);
	c_modem_task: cover property (@(posedge clk) disable iff (!rst_s2)
		mstate == MD_DONE);
	c_warm: cover property (@(posedge clk) disable iff (!rst_s2)
		state == ST_WARM ##1 state == ST_ACTIVE);
endmodule

// *** sim/power_state_sequencer_bench.sv ***
// self-checking bench for the power state sequencer
// assumes the host model drives the sleep pins, the bench all else
`timescale 1ns/1ps
module power_state_sequencer_bench
	import pss_pkg::*;
;
	logic clk, rst_b, cfg_valid, cfg_done, warm_reset_req, cold_off_req;
	logic wakeup, supply_low, step_hold, modem_reset_seq_bit, modem_off_bit;
	logic [CFG_AW-1:0] cfg_addr;
	logic [DLY_W+3:0] cfg_data;
	logic [DLY_W-1:0] modem_delay;
	logic [1:0] req_state;
	logic shallow_sleep_req_n, suspend_req_n, hibernate_req_n;
	logic core_power_good, platform_reset_n, serial_if_reset;
	logic core_boot_voltage_load, shutdown_warning_n, modem_off_n;
	logic under_voltage_flag, watch, f1, f2, f3, f4;
	logic [NUM_RAILS-1:0] rail_en, rail_save, clk_req, snap;
	logic [TASK_W-1:0] transition, last_tr;
	logic [TASK_W-1:0] exp_q[$];
	int n_errors, cmp_count, seed, i, k;

	// design and host model
	pss_top dut_u (.clk(clk), .rst_b(rst_b), .cfg_valid(cfg_valid),
		.cfg_addr(cfg_addr), .cfg_data(cfg_data), .cfg_done(cfg_done),
		.shallow_sleep_req_n(shallow_sleep_req_n),
		.suspend_req_n(suspend_req_n), .hibernate_req_n(hibernate_req_n),
		.warm_reset_req(warm_reset_req), .cold_off_req(cold_off_req),
		.wakeup(wakeup), .supply_low(supply_low), .step_hold(step_hold),
		.modem_reset_seq_bit(modem_reset_seq_bit),
		.modem_off_bit(modem_off_bit), .modem_delay(modem_delay),
		.core_power_good(core_power_good),
		.platform_reset_n(platform_reset_n), .rail_en(rail_en),
		.rail_save(rail_save), .clk_req(clk_req),
		.serial_if_reset(serial_if_reset),
		.core_boot_voltage_load(core_boot_voltage_load),
		.shutdown_warning_n(shutdown_warning_n), .modem_off_n(modem_off_n),
		.under_voltage_flag(under_voltage_flag), .transition(transition));
	pss_host_model host_u (.clk(clk), .req_state(req_state),
		.shallow_sleep_req_n(shallow_sleep_req_n),
		.suspend_req_n(suspend_req_n), .hibernate_req_n(hibernate_req_n));

	// 250 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// compare and count
	task check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// let n edges pass and their updates settle
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// bounded wait for the rail vector, then compare
	task wait_rails(input logic [15:0] exp);
		k = 0;
		while (rail_en !== exp && k < 600)
		begin
			tick(1);
			k++;
		end
		check("rail_en", rail_en, exp);
	endtask

	// bounded wait for power good (0) or the under-voltage flag (1)
	task wait_high(input logic sel_uv);
		k = 0;
		while ((sel_uv ? under_voltage_flag : core_power_good) !== 1'b1
			&& k < 600)
		begin
			tick(1);
			k++;
		end
	endtask

	// verdict
	task final_report;
		$display("errors %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// transition monitor: oldest note against each new code
	always @(posedge clk)
	begin
		if (watch && transition !== last_tr)
		begin
			if (exp_q.size() == 0)
				check("transition", 16'(transition), 16'(last_tr));
			else
				check("transition", 16'(transition), 16'(exp_q.pop_front()));
		end
		last_tr <= transition;
	end

	// watchdog
	initial
	begin
		repeat (60000) @(posedge clk);
		n_errors++;
		final_report;
	end

	// main sequence
	initial
	begin
		seed = 32'had2c;
		n_errors = 0;
		cmp_count = 0;
		watch = 1'b0;
		{rst_b, cfg_valid, cfg_done, warm_reset_req, cold_off_req} = 5'h00;
		{wakeup, supply_low, step_hold, modem_reset_seq_bit} = 4'h0;
		modem_off_bit = 1'b0;
		cfg_addr = 4'h0;
		cfg_data = 16'h0000;
		modem_delay = 12'h008;
		req_state = 2'h0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		tick(4);
		watch = 1'b1;
		// step i enables rail i after a random short delay
		for (i = 0; i < NUM_STEPS; i++)
		begin
			@(posedge clk);
			cfg_valid <= 1'b1;
			cfg_addr <= i[3:0];
			cfg_data <= {i[3:0], 12'($random(seed) & 15) + 12'h001};
		end
		@(posedge clk);
		cfg_valid <= 1'b0;
		wakeup <= 1'b1;
		tick(20);
		check("rail_en", rail_en, 16'h0000);
		@(posedge clk);
		cfg_done <= 1'b1;
		exp_q.push_back(TR_COLD_BOOT);
		@(posedge clk);
		cfg_done <= 1'b0;
		// pause the boot mid-walk
		tick(30);
		@(posedge clk);
		step_hold <= 1'b1;
		tick(3);
		snap = rail_en;
		tick(40);
		check("rail_en", rail_en, snap);
		@(posedge clk);
		step_hold <= 1'b0;
		wait_high(1'b0);
		check("pg", 16'(core_power_good), 16'h1);
		check("rst_n", 16'(platform_reset_n), 16'h0);
		check("rail_en", rail_en, RAIL_ALL);
		check("clk_req", 16'(clk_req != 0), 16'h1);
		tick(1);
		check("rst_n", 16'(platform_reset_n), 16'h1);
		// warm reset from active
		@(posedge clk);
		wakeup <= 1'b0;
		warm_reset_req <= 1'b1;
		exp_q.push_back(TR_WARM);
		@(posedge clk);
		warm_reset_req <= 1'b0;
		{f1, f2, f3, f4} = 4'h0;
		repeat (80)
		begin
			#1;
			f1 |= serial_if_reset;
			f2 |= core_boot_voltage_load;
			f3 |= !platform_reset_n;
			f4 |= (rail_en !== RAIL_ALL);
			@(posedge clk);
		end
		check("warm", {12'h000, f1, f2, f3, f4}, 16'h000e);
		check("rst_n", 16'(platform_reset_n), 16'h1);
		// shallow sleep, with a refused warm reset inside it
		@(posedge clk);
		req_state <= 2'h1;
		exp_q.push_back(TR_SLEEP_IN);
		wait_rails(RAIL_ALL & ~SLEEP_OFF_MASK);
		check("rail_save", rail_save, RAIL_ALL & ~SLEEP_OFF_MASK);
		@(posedge clk);
		warm_reset_req <= 1'b1;
		@(posedge clk);
		warm_reset_req <= 1'b0;
		tick(8);
		check("serial_rst", 16'(serial_if_reset), 16'h0);
		check("rst_n", 16'(platform_reset_n), 16'h1);
		@(posedge clk);
		req_state <= 2'h0;
		exp_q.push_back(TR_SLEEP_OUT);
		wait_rails(RAIL_ALL);
		check("rail_save", rail_save, 16'h0000);
		// suspend then hibernate, in and out
		for (i = 0; i < 2; i++)
		begin
			snap = i ? HIBERNATE_KEEP_MASK : SUSPEND_KEEP_MASK;
			@(posedge clk);
			req_state <= 2'(i + 2);
			exp_q.push_back(i ? TR_HIB_IN : TR_SUSP_IN);
			wait_rails(snap);
			check("rail_save", rail_save, snap);
			@(posedge clk);
			req_state <= 2'h0;
			exp_q.push_back(i ? TR_HIB_OUT : TR_SUSP_OUT);
			wait_rails(RAIL_ALL);
			check("rail_save", rail_save, 16'h0000);
		end
		// modem off level, then the modem task
		@(posedge clk);
		modem_off_bit <= 1'b1;
		tick(4);
		check("modem_off_n", 16'(modem_off_n), 16'h0);
		@(posedge clk);
		modem_off_bit <= 1'b0;
		tick(4);
		@(posedge clk);
		modem_reset_seq_bit <= 1'b1;
		exp_q.push_back(TR_MODEM);
		@(posedge clk);
		modem_reset_seq_bit <= 1'b0;
		k = 0;
		f1 = 1'b0;
		repeat (200)
		begin
			#1;
			k += !modem_off_n;
			f1 |= !shutdown_warning_n;
			@(posedge clk);
		end
		check("off_len", 16'(k), 16'(modem_delay) + 16'h1);
		check("warn_seen", 16'(f1), 16'h1);
		// cold off, stay down, wake up
		@(posedge clk);
		cold_off_req <= 1'b1;
		exp_q.push_back(TR_COLD_OFF);
		tick(6);
		check("warn_n", 16'(shutdown_warning_n), 16'h0);
		wait_rails(16'h0000);
		@(posedge clk);
		cold_off_req <= 1'b0;
		tick(50);
		check("rail_en", rail_en, 16'h0000);
		@(posedge clk);
		wakeup <= 1'b1;
		exp_q.push_back(TR_COLD_BOOT);
		wait_high(1'b0);
		check("pg", 16'(core_power_good), 16'h1);
		check("rail_en", rail_en, RAIL_ALL);
		check("pending", 16'(exp_q.size()), 16'h0000);
		// under-voltage
		watch = 1'b0;
		@(posedge clk);
		supply_low <= 1'b1;
		wait_high(1'b1);
		check("uv_flag", 16'(under_voltage_flag), 16'h1);
		wait_rails(16'h0000);
		final_report;
	end
endmodule

// *** sim/pss_host_model.sv ***
// host processor model: drives the three active-low sleep request pins
// assumes the bench picks the requested state on the shared clock
`timescale 1ns/1ps
module pss_host_model
	import pss_pkg::*;
(
	// clock
	input wire logic clk,
	// requested state: 0 active, 1 shallow, 2 suspend, 3 hibernate
	input wire logic [1:0] req_state,
	// sleep pins toward the sequencer
	output logic shallow_sleep_req_n,
	output logic suspend_req_n,
	output logic hibernate_req_n
);
	// pins move just after an edge, only one request low at a time
	always @(posedge clk)
	begin
		shallow_sleep_req_n <= (req_state != 2'h1);
		suspend_req_n <= (req_state != 2'h2);
		hibernate_req_n <= (req_state != 2'h3);
	end
endmodule
